/* File: common/spx_pkg.sv */
// Constants, types and opcode encodings for the stack and subtract execution unit
package spx_pkg;
  // ****************************************
  // Flag bit positions
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_F = 6;
  localparam int FLAG_E = 7;
  // ****************************************
  // Selector bits and constants
  // ****************************************
  localparam int SEL_CC = 0;
  localparam int SEL_A = 1;
  localparam int SEL_B = 2;
  localparam int SEL_DP = 3;
  localparam int SEL_X = 4;
  localparam int SEL_Y = 5;
  localparam int SEL_SP = 6;
  localparam int SEL_PC = 7;
  localparam logic [15:0] TRAP_VECTOR = 16'hfffa;
  localparam logic [7:0] SEL_ALL = 8'hff;
  localparam logic [7:0] SEL_PC_ONLY = 8'h80;
  localparam logic [7:0] SEL_ENTIRE = 8'hfe;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h50;
  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [3:0] {
    pull_hardware_stack_op = 4'h0,
    pull_user_stack_op = 4'h1,
    rotate_left_op = 4'h2,
    rotate_right_op = 4'h3,
    interrupt_return_op = 4'h4,
    subroutine_return_op = 4'h5,
    sub_borrow_acc_a_op = 4'h6,
    sign_extend_op = 4'h7,
    store_byte_op = 4'h8,
    store_word_op = 4'h9,
    subtract_byte_op = 4'ha,
    subtract_word_op = 4'hb,
    software_trap_op = 4'hc
  } spx_op_t;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PULL = 3'b001,
    ST_PUSH = 3'b010,
    ST_VEC = 3'b011,
    ST_RD = 3'b100,
    ST_WR = 3'b101,
    ST_DONE = 3'b110
  } spx_state_t;
endpackage : spx_pkg

/* File: tb/spx_exec_tb.sv */
// Self-checking bench for the stack and subtract execution unit
`timescale 1ns/1ps
module spx_exec_tb
  import spx_pkg::*;
;
  // ****************************************
  // Stimulus, outputs and expected state
  // ****************************************
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, target_b = 1'b0;
  logic [3:0] op = 4'h0;
  logic [7:0] sel = 8'h00;
  logic [15:0] ea = 16'h0000;
  logic mem_rd, mem_wr, busy, done;
  logic [15:0] mem_addr, index_x, index_y, user_stack_pointer, hardware_stack_pointer;
  logic [15:0] prog_counter;
  logic [7:0] mem_wdata, mem_rdata, flag_register, accumulator_a, accumulator_b;
  logic [7:0] page_register;
  logic [7:0] r_cc = RST_FLAGS, r_a = 8'h00, r_b = 8'h00, r_dp = 8'h00; // Expected bytes
  logic [15:0] r_x = 16'h0000, r_y = 16'h0000, r_u = 16'h0000, r_s = 16'h0000;
  logic [15:0] r_pc = 16'h0000; // Expected words
  logic [23:0] wq [$]; // Expected writes, address and byte
  int mismatches = 0;
  int cmp_count = 0;
  spx_exec dut (.clk, .rst_n, .start, .op, .sel, .ea, .target_b, .mem_rdata, .mem_rd,
    .mem_wr, .mem_addr, .mem_wdata, .busy, .done, .flag_register, .accumulator_a,
    .accumulator_b, .page_register, .index_x, .index_y, .user_stack_pointer,
    .hardware_stack_pointer, .prog_counter);
  spx_mem_model mem_i (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
  // Free-running clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic test_done();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // One comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] m(input logic [15:0] a);
    return mem_i.mem[a];
  endfunction : m
  // Stack byte and word pulls, pushes
  task automatic pop(inout logic [15:0] p, output logic [7:0] v);
    v = m(p);
    p = p + 16'h0001;
  endtask : pop
  task automatic pw(inout logic [15:0] p, output logic [15:0] v);
    v = {m(p), m(p + 16'h0001)};
    p = p + 16'h0002;
  endtask : pw
  task automatic push(inout logic [15:0] p, input logic [7:0] v);
    p = p - 16'h0001;
    wq.push_back({p, v});
  endtask : push
  task automatic nz(input logic [15:0] v, input logic w);
    r_cc[FLAG_N] = w ? v[15] : v[7];
    r_cc[FLAG_Z] = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
  endtask : nz
  task automatic sub8(inout logic [7:0] r, input logic [7:0] mv, input logic ci);
    logic [8:0] d;
    d = {1'b0, r} - {1'b0, mv} - {8'h00, ci};
    r_cc[FLAG_V] = (r[7] ^ mv[7]) & (r[7] ^ d[7]);
    r_cc[FLAG_C] = d[8]; // Borrow
    r = d[7:0];
    nz({8'h00, r}, 1'b0);
  endtask : sub8
  // Expected effect of one operation
  task automatic ref_exec(input logic [3:0] o, input logic [7:0] s, input logic [15:0] e,
                          input logic t);
    logic [15:0] p;
    logic [16:0] d;
    logic [7:0] v;
    p = (o == pull_user_stack_op) ? r_u : r_s;
    v = r_a;
    case (o)
      pull_hardware_stack_op, pull_user_stack_op: begin
        if (s[0]) pop(p, r_cc);
        if (s[1]) pop(p, r_a);
        if (s[2]) pop(p, r_b);
        if (s[3]) pop(p, r_dp);
        if (s[4]) pw(p, r_x);
        if (s[5]) pw(p, r_y);
        if (s[6] && o == pull_user_stack_op) pw(p, r_s);
        if (s[6] && o != pull_user_stack_op) pw(p, r_u);
        if (s[7]) pw(p, r_pc);
        if (o == pull_user_stack_op) r_u = p;
        else r_s = p;
      end
      rotate_left_op: begin
        r_a = {v[6:0], r_cc[FLAG_C]};
        r_cc[FLAG_C] = v[7];
        r_cc[FLAG_V] = v[7] ^ v[6];
        nz({8'h00, r_a}, 1'b0);
      end
      rotate_right_op: begin
        r_a = {r_cc[FLAG_C], v[7:1]};
        r_cc[FLAG_C] = v[0];
        nz({8'h00, r_a}, 1'b0);
      end
      interrupt_return_op: begin
        pop(p, r_cc);
        if (r_cc[FLAG_E]) begin
          pop(p, r_a);
          pop(p, r_b);
          pop(p, r_dp);
          pw(p, r_x);
          pw(p, r_y);
          pw(p, r_u);
        end
        pw(p, r_pc);
        r_s = p;
      end
      subroutine_return_op: begin
        pw(p, r_pc);
        r_s = p;
      end
      sub_borrow_acc_a_op, subtract_byte_op: begin
        v = (o == subtract_byte_op) ? 8'h00 : {7'h00, r_cc[FLAG_C]};
        if (t) sub8(r_b, m(e), v[0]);
        else sub8(r_a, m(e), v[0]);
      end
      sign_extend_op: begin
        r_a = r_b[7] ? 8'hff : 8'h00;
        nz({r_a, r_b}, 1'b1);
      end
      store_byte_op: begin
        v = t ? r_b : r_a;
        wq.push_back({e, v});
        nz({8'h00, v}, 1'b0);
        r_cc[FLAG_V] = 1'b0;
      end
      store_word_op: begin
        wq.push_back({e, r_a});
        wq.push_back({e + 16'h0001, r_b});
        nz({r_a, r_b}, 1'b1);
        r_cc[FLAG_V] = 1'b0;
      end
      subtract_word_op: begin
        v = m(e);
        d = {1'b0, r_a, r_b} - {1'b0, v, m(e + 16'h0001)};
        r_cc[FLAG_V] = (r_a[7] ^ v[7]) & (r_a[7] ^ d[15]);
        r_cc[FLAG_C] = d[16];
        {r_a, r_b} = d[15:0];
        nz(d[15:0], 1'b1);
      end
      default: begin
        r_cc[FLAG_E] = 1'b1;
        push(p, r_pc[7:0]);
        push(p, r_pc[15:8]);
        push(p, r_u[7:0]);
        push(p, r_u[15:8]);
        push(p, r_y[7:0]);
        push(p, r_y[15:8]);
        push(p, r_x[7:0]);
        push(p, r_x[15:8]);
        push(p, r_dp);
        push(p, r_b);
        push(p, r_a);
        push(p, r_cc);
        r_s = p;
        r_cc[FLAG_I] = 1'b1;
        r_cc[FLAG_F] = 1'b1;
      end
    endcase
  endtask : ref_exec
  // Edges from the start edge to the done edge, zero for pulls, interrupt return and trap
  function automatic int lat(input logic [3:0] o);
    case (o)
      rotate_left_op, rotate_right_op, sign_extend_op, store_byte_op: return 1;
      store_word_op: return 2;
      sub_borrow_acc_a_op, subtract_byte_op: return 3;
      subtract_word_op: return 5;
      subroutine_return_op: return 8;
      default: return 0;
    endcase
  endfunction : lat
  // Compare all registers, flags under a mask
  task automatic chk_regs(input logic [7:0] fm);
    chk({8'h00, flag_register & fm}, {8'h00, r_cc & fm});
    chk({accumulator_a, accumulator_b}, {r_a, r_b});
    chk({8'h00, page_register}, {8'h00, r_dp});
    chk(index_x, r_x);
    chk(index_y, r_y);
    chk(user_stack_pointer, r_u);
    chk(hardware_stack_pointer, r_s);
    chk(prog_counter, r_pc);
  endtask : chk_regs
  // Issue one operation; rf keeps start up a cycle, which must be ignored
  task automatic run_op(input logic [3:0] o, input logic [7:0] s, input logic [15:0] e,
                        input logic t, input logic rf);
    int n;
    wq.delete();
    ref_exec(o, s, e, t);
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    sel <= s;
    ea <= e;
    target_b <= t;
    @(posedge clk);
    start <= rf;
    if (rf) op <= software_trap_op;
    n = 0;
    do begin
      @(posedge clk);
      start <= 1'b0;
      op <= o;
      n++;
      #1;
      if (done !== 1'b1) chk(16'(busy), 16'h0001); // Busy while the operation runs
    end while (done !== 1'b1 && n < 300);
    if (n >= 300) begin
      mismatches++;
      test_done();
    end
    chk(16'(busy), 16'h0000); // Busy ends with done
    if (lat(o) != 0) chk(16'(n), 16'(lat(o)));
    if (o == software_trap_op) r_pc = {m(TRAP_VECTOR), m(TRAP_VECTOR + 16'h0001)};
    chk_regs((o == subtract_byte_op || o == sub_borrow_acc_a_op) ? 8'hdf : 8'hff);
    foreach (wq[i]) chk({8'h00, m(wq[i][23:8])}, {8'h00, wq[i][7:0]});
  endtask : run_op
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(55));
    for (int i = 0; i < 65536; i++) mem_i.mem[i] = 8'($urandom);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk_regs(8'hff); // Reset values
    run_op(pull_hardware_stack_op, 8'hff, 16'h0000, 1'b0, 1'b0);
    run_op(pull_user_stack_op, 8'hff, 16'h0000, 1'b0, 1'b1);
    run_op(pull_user_stack_op, 8'h00, 16'h0000, 1'b0, 1'b0);
    run_op(software_trap_op, 8'h00, 16'h0000, 1'b0, 1'b0);
    run_op(interrupt_return_op, 8'h00, 16'h0000, 1'b0, 1'b0);
    mem_i.mem[r_s] = 8'h0f;
    run_op(interrupt_return_op, 8'h00, 16'h0000, 1'b0, 1'b0);
    run_op(store_word_op, 8'h00, 16'hffff, 1'b0, 1'b0);
    run_op(sign_extend_op, 8'h00, 16'h0000, 1'b0, 1'b1);
    for (int k = 0; k < 13; k++) run_op(4'(k), 8'h81, 16'h8000, 1'b1, 1'b0);
    repeat (80) begin
      run_op(4'($urandom_range(12)), 8'($urandom), 16'($urandom), 1'($urandom),
             ($urandom_range(3) == 0));
    end
    test_done();
  end
endmodule : spx_exec_tb

/* File: tb/spx_mem_model.sv */
// Byte-wide memory partner holding stacks, operands and vectors
`timescale 1ns/1ps
module spx_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // ****************************************
  // Storage and read answer
  // ****************************************
  logic [7:0] mem [0:65535]; // Filled by the bench at time zero
  logic [7:0] q = 8'h00; // Byte on the read data line
  // Read answers the cycle after the strobe; otherwise the line toggles
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      q <= mem[mem_addr];
    end else begin
      q <= ~q; // Stale data never looks valid
    end
  end
  assign mem_rdata = q;
endmodule : spx_mem_model

/* File: verilog/spx_exec.sv */
// Execution unit for stack pulls, rotates, returns, subtracts, stores and trap
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module spx_exec
  import spx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start, // One-cycle request
  input wire logic [3:0] op, // Operation code
  input wire logic [7:0] sel, // Pull selector byte
  input wire logic [15:0] ea, // Operand address M
  input wire logic target_b, // Byte stores and subtracts use B, else A; rotates always use A
  input wire logic [7:0] mem_rdata, // Read data, one cycle after mem_rd
  output logic mem_rd, // Read strobe
  output logic mem_wr, // Write strobe
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic busy,
  output logic done, // One-cycle completion pulse
  output logic [7:0] flag_register,
  output logic [7:0] accumulator_a,
  output logic [7:0] accumulator_b,
  output logic [7:0] page_register,
  output logic [15:0] index_x,
  output logic [15:0] index_y,
  output logic [15:0] user_stack_pointer,
  output logic [15:0] hardware_stack_pointer,
  output logic [15:0] prog_counter
);
  // ****************************************
  // Helpers
  // ****************************************
  // Lowest set bit index of a mask, zero when empty
  function automatic logic [2:0] low_bit(input logic [7:0] m);
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        return i[2:0];
      end
    end
    return 3'h0;
  endfunction : low_bit
  // Highest set bit index of a mask, zero when empty
  function automatic logic [2:0] high_bit(input logic [7:0] m);
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        return i[2:0];
      end
    end
    return 3'h0;
  endfunction : high_bit
  // Register is 16 bits wide
  function automatic logic is_word(input logic [2:0] b);
    return b >= 3'h4;
  endfunction : is_word
  // ****************************************
  // State
  // ****************************************
  spx_state_t state; // Sequencer state
  spx_op_t cur_op; // Latched operation
  logic [7:0] mask; // Registers still to move
  logic half; // Second byte of word
  logic use_user; // Pull source is user stack
  logic [7:0] rd_hi; // Held high byte of operand
  logic rd_wait; // Read data due this cycle
  logic [2:0] cur_bit;
  logic [15:0] word_val;
  logic [7:0] byte_val;
  logic [7:0] opnd; // Byte operand, accumulator B or A per target_b, not registered
  logic [8:0] diff8;
  logic [16:0] diff16;
  logic [15:0] dacc;
  assign cur_bit = state == ST_PUSH ? high_bit(mask) : low_bit(mask); // Push walks high first
  assign dacc = {accumulator_a, accumulator_b};
  assign opnd = target_b ? accumulator_b : accumulator_a;
  // Value of the register being pushed
  always_comb begin
    word_val = RST16;
    byte_val = BYTE_ZERO;
    case (cur_bit)
      3'h0: byte_val = flag_register;
      3'h1: byte_val = accumulator_a;
      3'h2: byte_val = accumulator_b;
      3'h3: byte_val = page_register;
      3'h4: word_val = index_x;
      3'h5: word_val = index_y;
      3'h6: word_val = user_stack_pointer;
      default: word_val = prog_counter;
    endcase
  end
  // Subtract datapaths, borrow from carry for SBC
  assign diff8 = {1'b0, opnd} - {1'b0, mem_rdata}
    - {8'h00, cur_op == sub_borrow_acc_a_op && flag_register[FLAG_C]};
  assign diff16 = {1'b0, dacc} - {1'b0, rd_hi, mem_rdata};
  // ****************************************
  // Sequencer and datapath
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur_op <= pull_hardware_stack_op;
      mask <= BYTE_ZERO;
      half <= 1'b0;
      use_user <= 1'b0;
      rd_hi <= BYTE_ZERO;
      rd_wait <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= RST16;
      mem_wdata <= BYTE_ZERO;
      busy <= 1'b0;
      done <= 1'b0;
      flag_register <= RST_FLAGS;
      accumulator_a <= BYTE_ZERO;
      accumulator_b <= BYTE_ZERO;
      page_register <= BYTE_ZERO;
      index_x <= RST16;
      index_y <= RST16;
      user_stack_pointer <= RST16;
      hardware_stack_pointer <= RST16;
      prog_counter <= RST16;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      done <= 1'b0;
      case (state)
        // Accept and launch an operation
        ST_IDLE: begin
          if (start) begin
            cur_op <= spx_op_t'(op);
            busy <= 1'b1;
            half <= 1'b0;
            rd_wait <= 1'b0;
            case (spx_op_t'(op))
              pull_hardware_stack_op: begin
                mask <= sel;
                use_user <= 1'b0;
                state <= ST_PULL;
              end
              pull_user_stack_op: begin
                mask <= sel;
                use_user <= 1'b1;
                state <= ST_PULL;
              end
              interrupt_return_op: begin
                mask <= 8'h01; // Flags first, rest after
                use_user <= 1'b0;
                state <= ST_PULL;
              end
              subroutine_return_op: begin
                mask <= SEL_PC_ONLY;
                use_user <= 1'b0;
                state <= ST_PULL;
              end
              software_trap_op: begin
                flag_register[FLAG_E] <= 1'b1;
                mask <= SEL_ALL; // U goes in the pointer slot
                state <= ST_PUSH;
              end
              rotate_left_op: begin
                accumulator_a <= {accumulator_a[6:0], flag_register[FLAG_C]};
                flag_register[FLAG_C] <= accumulator_a[7];
                flag_register[FLAG_V] <= accumulator_a[6] ^ accumulator_a[7];
                flag_register[FLAG_N] <= accumulator_a[6];
                flag_register[FLAG_Z] <= {accumulator_a[6:0], flag_register[FLAG_C]} == 8'h00;
                state <= ST_DONE;
              end
              rotate_right_op: begin
                accumulator_a <= {flag_register[FLAG_C], accumulator_a[7:1]};
                flag_register[FLAG_C] <= accumulator_a[0];
                flag_register[FLAG_N] <= flag_register[FLAG_C];
                flag_register[FLAG_Z] <= {flag_register[FLAG_C], accumulator_a[7:1]} == 8'h00;
                state <= ST_DONE;
              end
              sign_extend_op: begin
                accumulator_a <= accumulator_b[7] ? BYTE_ONES : BYTE_ZERO;
                flag_register[FLAG_N] <= accumulator_b[7];
                flag_register[FLAG_Z] <= !accumulator_b[7] && accumulator_b == BYTE_ZERO;
                state <= ST_DONE;
              end
              store_byte_op: begin
                mem_wr <= 1'b1;
                mem_addr <= ea;
                mem_wdata <= opnd;
                flag_register[FLAG_N] <= opnd[7];
                flag_register[FLAG_Z] <= opnd == BYTE_ZERO;
                flag_register[FLAG_V] <= 1'b0;
                state <= ST_DONE;
              end
              store_word_op: begin
                mem_wr <= 1'b1;
                mem_addr <= ea;
                mem_wdata <= accumulator_a;
                flag_register[FLAG_N] <= accumulator_a[7];
                flag_register[FLAG_Z] <= dacc == RST16;
                flag_register[FLAG_V] <= 1'b0;
                state <= ST_WR;
              end
              default: begin
                mem_rd <= 1'b1; // Fetch operand at M
                mem_addr <= ea;
                state <= ST_RD;
              end
            endcase
          end
        end
        // Second byte of a word store
        ST_WR: begin
          mem_wr <= 1'b1;
          mem_addr <= mem_addr + ONE16;
          mem_wdata <= accumulator_b;
          state <= ST_DONE;
        end
        // Operand read and subtract
        ST_RD: begin
          if (!rd_wait) begin
            rd_wait <= 1'b1;
          end else if (cur_op == subtract_word_op && !half) begin
            rd_hi <= mem_rdata; // High byte at M
            half <= 1'b1;
            rd_wait <= 1'b0;
            mem_rd <= 1'b1;
            mem_addr <= mem_addr + ONE16;
          end else if (cur_op == subtract_word_op) begin
            {accumulator_a, accumulator_b} <= diff16[15:0];
            flag_register[FLAG_N] <= diff16[15];
            flag_register[FLAG_Z] <= diff16[15:0] == RST16;
            flag_register[FLAG_V] <= (dacc[15] ^ rd_hi[7]) & (dacc[15] ^ diff16[15]);
            flag_register[FLAG_C] <= diff16[16];
            state <= ST_DONE;
          end else begin
            if (target_b) begin
              accumulator_b <= diff8[7:0];
            end else begin
              accumulator_a <= diff8[7:0];
            end
            flag_register[FLAG_N] <= diff8[7];
            flag_register[FLAG_Z] <= diff8[7:0] == BYTE_ZERO;
            flag_register[FLAG_V] <= (opnd[7] ^ mem_rdata[7]) & (opnd[7] ^ diff8[7]);
            flag_register[FLAG_C] <= diff8[8]; // Half carry left as is
            state <= ST_DONE;
          end
        end
        // Pull one byte per read, low selector bit first
        ST_PULL: begin
          if (mask == BYTE_ZERO) begin
            state <= ST_DONE;
          end else if (!rd_wait) begin
            mem_rd <= 1'b1;
            mem_addr <= use_user ? user_stack_pointer : hardware_stack_pointer;
            if (use_user) begin
              user_stack_pointer <= user_stack_pointer + ONE16;
            end else begin
              hardware_stack_pointer <= hardware_stack_pointer + ONE16;
            end
            rd_wait <= 1'b1;
          end else if (!mem_rd) begin // Data stands the cycle after the strobe
            rd_wait <= 1'b0;
            case (cur_bit)
              3'h0: begin
                flag_register <= mem_rdata;
                if (cur_op == interrupt_return_op) begin
                  mask <= mem_rdata[FLAG_E] ? SEL_ENTIRE : SEL_PC_ONLY;
                end
              end
              3'h1: accumulator_a <= mem_rdata;
              3'h2: accumulator_b <= mem_rdata;
              3'h3: page_register <= mem_rdata;
              3'h4: index_x <= half ? {index_x[15:8], mem_rdata} : {mem_rdata, index_x[7:0]};
              3'h5: index_y <= half ? {index_y[15:8], mem_rdata} : {mem_rdata, index_y[7:0]};
              3'h6: begin
                // The other stack pointer; own pointer never loaded
                if (use_user) begin
                  hardware_stack_pointer <= half ? {hardware_stack_pointer[15:8], mem_rdata}
                    : {mem_rdata, hardware_stack_pointer[7:0]};
                end else begin
                  user_stack_pointer <= half ? {user_stack_pointer[15:8], mem_rdata}
                    : {mem_rdata, user_stack_pointer[7:0]};
                end
              end
              default: prog_counter <= half ? {prog_counter[15:8], mem_rdata}
                : {mem_rdata, prog_counter[7:0]};
            endcase
            if (is_word(cur_bit) && !half) begin
              half <= 1'b1; // High byte first from lower address
            end else begin
              half <= 1'b0;
              if (!(cur_bit == 3'h0 && cur_op == interrupt_return_op)) begin
                mask[cur_bit] <= 1'b0;
              end
            end
          end
        end
        // Push pre-decrement, high selector bit first, low byte first
        ST_PUSH: begin
          if (mask == BYTE_ZERO) begin
            flag_register[FLAG_I] <= 1'b1;
            flag_register[FLAG_F] <= 1'b1;
            mem_rd <= 1'b1;
            mem_addr <= TRAP_VECTOR;
            half <= 1'b0;
            rd_wait <= 1'b0;
            state <= ST_VEC;
          end else begin
            mem_wr <= 1'b1;
            mem_addr <= hardware_stack_pointer - ONE16;
            hardware_stack_pointer <= hardware_stack_pointer - ONE16;
            if (is_word(cur_bit)) begin
              mem_wdata <= half ? word_val[15:8] : word_val[7:0];
              half <= !half;
              if (half) begin
                mask[cur_bit] <= 1'b0;
              end
            end else begin
              mem_wdata <= byte_val;
              mask[cur_bit] <= 1'b0;
            end
          end
        end
        // Vector fetch, high byte at FFFA
        ST_VEC: begin
          if (!rd_wait) begin
            rd_wait <= 1'b1;
          end else if (!half) begin
            prog_counter[15:8] <= mem_rdata;
            half <= 1'b1;
            rd_wait <= 1'b0;
            mem_rd <= 1'b1;
            mem_addr <= TRAP_VECTOR + ONE16;
          end else begin
            prog_counter[7:0] <= mem_rdata;
            state <= ST_DONE;
          end
        end
        // Finish
        default: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rts_flags_a: assert property (state == ST_IDLE && start && op == 4'h5 |=>
    $stable(flag_register)[*4]) else $error("flags changed in subroutine return");
  store_flags_a: assert property (state == ST_IDLE && start && op == 4'h8 |=>
    mem_wr && !flag_register[FLAG_V] && flag_register[FLAG_Z] == (mem_wdata == BYTE_ZERO))
    else $error("byte store flags wrong");
  word_store_a: assert property (mem_wr && state == ST_WR |=> mem_wr &&
    mem_addr == $past(mem_addr) + ONE16) else $error("word store not consecutive");
  trap_vec_a: assert property (state == ST_PUSH && mask == BYTE_ZERO |=> mem_rd &&
    mem_addr == TRAP_VECTOR && flag_register[FLAG_I] && flag_register[FLAG_F])
    else $error("trap vector fetch wrong");
  push_dec_a: assert property (state == ST_PUSH && mask != BYTE_ZERO |=> mem_wr &&
    hardware_stack_pointer == $past(hardware_stack_pointer) - ONE16)
    else $error("push not predecremented");
  pull_inc_a: assert property (mem_rd && state == ST_PULL && !use_user |->
    hardware_stack_pointer == mem_addr + ONE16) else $error("hardware pull pointer wrong");
  upull_inc_a: assert property (mem_rd && state == ST_PULL && use_user |->
    user_stack_pointer == mem_addr + ONE16) else $error("user pull pointer wrong");
  sign_ext_a: assert property (state == ST_IDLE && start && op == 4'h7 |=>
    accumulator_a == {8{$past(accumulator_b[7])}}) else $error("sign extend wrong");
  trap_cv: cover property (state == ST_VEC ##[1:8] done);
  ireturn_cv: cover property (state == ST_PULL && cur_op == interrupt_return_op && mask == SEL_ENTIRE);
  sub_cv: cover property (state == ST_RD && cur_op == subtract_word_op ##[1:6] done);
endmodule : spx_exec
